/* logic/rmls_consts.vh */
/*
 * Constants of the rate-match and lane-sync block: 10-bit code groups,
 * lane-sync counts, flag timing and pulse lengths.
 * Assumes code groups arrive with bit a (first on the line) as bit 9.
 */
`ifndef RMLS_CONSTS_VH
`define RMLS_CONSTS_VH

// ----------------------------------------------------------------------
// Code groups, both running disparities
// ----------------------------------------------------------------------
`define RMLS_K285_N        10'h0fa
`define RMLS_K285_P        10'h305
`define RMLS_D162_N        10'h1b5
`define RMLS_D162_P        10'h245
`define RMLS_D22_N         10'h2d5
`define RMLS_D22_P         10'h125
`define RMLS_K297_N        10'h2e8
`define RMLS_K297_P        10'h117

// ----------------------------------------------------------------------
// Default control and skip patterns of the packet-interconnect matcher
// ----------------------------------------------------------------------
`define RMLS_CTRL1         `RMLS_K285_P
`define RMLS_SKIP1         `RMLS_K297_P
`define RMLS_CTRL2         `RMLS_K285_N
`define RMLS_SKIP2         `RMLS_K297_N

// ----------------------------------------------------------------------
// Lane sync counts
// ----------------------------------------------------------------------
`define RMLS_SYNC_COMMAS   8'd127
`define RMLS_SYNC_ERRS     2'd3
`define RMLS_SYNC_GOODS    8'd255

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RMLS_CLK_PERIOD_NS  4
`define RMLS_LINK_PERIOD_NS 48
`define RMLS_FLAG_LINK_CYC  2
`define RMLS_FLAG_CYC       ((`RMLS_FLAG_LINK_CYC * `RMLS_LINK_PERIOD_NS + `RMLS_CLK_PERIOD_NS - 1) / `RMLS_CLK_PERIOD_NS)
`define RMLS_RD_DIV         (`RMLS_LINK_PERIOD_NS / `RMLS_CLK_PERIOD_NS)
`define RMLS_PULSE_CYC      2'd2

`endif

/* logic/rmls_fifo.v */
/*
 * Elastic storage of the rate matcher: flip-flop array with read and
 * write pointers and a fill level.
 * Assumes both ports sit on clk_i; writes when full are ignored.
 */
`timescale 1ns/100ps
`default_nettype none

module rmls_fifo #(
    parameter W  = 10,
    parameter AW = 4
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          wr_en_i,
    input  wire [W-1:0]  wr_data_i,
    input  wire          rd_en_i,
    output wire [W-1:0]  rd_data_o,
    output wire          full_o,
    output wire          empty_o,
    output wire [AW:0]   level_o
);

    localparam DEPTH = 1 << AW;

    reg [W-1:0] mem_q [0:DEPTH-1];
    reg [AW:0]  wptr_q;
    reg [AW:0]  rptr_q;

    // ------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------
    assign level_o   = wptr_q - rptr_q;
    assign full_o    = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
    assign empty_o   = (wptr_q == rptr_q);
    assign rd_data_o = mem_q[rptr_q[AW-1:0]];

    // Storage, no reset needed on data
    always @(posedge clk_i) begin
        if (wr_en_i && !full_o) begin
            mem_q[wptr_q[AW-1:0]] <= wr_data_i;
        end
    end

    // Pointers
    always @(posedge clk_i) begin
        if (rst_i) begin
            wptr_q <= {(AW+1){1'b0}};
            rptr_q <= {(AW+1){1'b0}};
        end else begin
            if (wr_en_i && !full_o) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (rd_en_i && !empty_o) begin
                rptr_q <= rptr_q + 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* logic/rmls_lane_sync.v */
/*
 * Lane synchronisation state machine for both the gigabit and packet-interconnect modes.
 * Assumes one code group per sym_stb_i with its decoder error flag.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rmls_consts.vh"

module rmls_lane_sync (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        sym_stb_i,
    input  wire [9:0]  sym_i,
    input  wire        sym_err_i,
    output wire        sync_o
);

    localparam ST_LOSS = 1'b0;
    localparam ST_SYNC = 1'b1;

    reg       state_q;
    reg [7:0] comma_cnt_q;
    reg [7:0] good_cnt_q;
    reg [1:0] err_cnt_q;

    // Whole 10-bit comma only; short patterns never match
    wire comma = (sym_i == `RMLS_K285_N) || (sym_i == `RMLS_K285_P);

    assign sync_o = (state_q == ST_SYNC);

    // ------------------------------------------------------------------
    // Acquire on commas, lose on errors, heal on long good runs
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q     <= ST_LOSS;
            comma_cnt_q <= 8'h00;
            good_cnt_q  <= 8'h00;
            err_cnt_q   <= 2'h0;
        end else if (sym_stb_i) begin
            case (state_q)
                ST_LOSS: begin
                    if (sym_err_i) begin
                        comma_cnt_q <= 8'h00;
                    end else if (comma) begin
                        if (comma_cnt_q == `RMLS_SYNC_COMMAS - 8'd1) begin
                            state_q     <= ST_SYNC;
                            comma_cnt_q <= 8'h00;
                            err_cnt_q   <= 2'h0;
                            good_cnt_q  <= 8'h00;
                        end else begin
                            comma_cnt_q <= comma_cnt_q + 8'd1;
                        end
                    end
                end
                ST_SYNC: begin
                    if (sym_err_i) begin
                        good_cnt_q <= 8'h00;
                        if (err_cnt_q == `RMLS_SYNC_ERRS - 2'd1) begin
                            state_q   <= ST_LOSS;
                            err_cnt_q <= 2'h0;
                        end else begin
                            err_cnt_q <= err_cnt_q + 2'd1;
                        end
                    end else if (good_cnt_q == `RMLS_SYNC_GOODS - 8'd1) begin
                        good_cnt_q <= 8'h00;
                        if (err_cnt_q != 2'h0) begin
                            err_cnt_q <= err_cnt_q - 2'd1;
                        end
                    end else begin
                        good_cnt_q <= good_cnt_q + 8'd1;
                    end
                end
                default: begin
                    state_q <= ST_LOSS;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* logic/rmls_rate_match.v */
/*
 * Receive clock compensation: samples the recovered link clock and code
 * groups, tracks lane sync, and runs an elastic FIFO that adds or drops
 * idle sets (gigabit mode) or skip patterns (packet-interconnect mode).
 * Assumes rx_code_i changes away from the rising edge of rx_clk_i and is
 * stable for at least half a link period around it; fabric inputs are
 * on clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rmls_consts.vh"

module rmls_rate_match #(
    parameter AW     = 4,
    parameter LO_LVL = 4,
    parameter HI_LVL = 12,
    parameter RD_DIV = `RMLS_RD_DIV
) (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        rx_clk_i,
    input  wire [9:0]  rx_code_i,
    input  wire        rx_code_err_i,
    input  wire        mode_srio_i,
    input  wire        srio_rm_en_i,
    input  wire        autoneg_en_i,
    input  wire        rx_logic_rst_i,
    output wire [9:0]  rx_sym_o,
    output wire        rx_sym_vld_o,
    output wire        sync_o,
    output wire        rm_del_o,
    output wire        rm_ins_o,
    output wire        rm_full_o,
    output wire        rm_empty_o
);

    localparam integer FLAG_CYC_I = `RMLS_FLAG_CYC;
    localparam [4:0]   FLAG_CYC   = FLAG_CYC_I[4:0];
    localparam integer RD_LAST_I  = RD_DIV - 1;
    localparam [7:0]   RD_LAST    = RD_LAST_I[7:0];
    localparam [AW:0]  LO_LEVEL   = LO_LVL;
    localparam [AW:0]  HI_LEVEL   = HI_LVL;

    // ------------------------------------------------------------------
    // Code group classes, used on both the write and read sides
    // ------------------------------------------------------------------
    function is_comma;
        input [9:0] c;
        begin
            is_comma = (c == `RMLS_K285_N) || (c == `RMLS_K285_P);
        end
    endfunction

    function is_idle2;
        input [9:0] c;
        begin
            is_idle2 = (c == `RMLS_D162_N) || (c == `RMLS_D162_P);
        end
    endfunction

    function is_cfg2;
        input [9:0] c;
        begin
            is_cfg2 = (c == `RMLS_D22_N) || (c == `RMLS_D22_P);
        end
    endfunction

    // Control pattern followed by its own skip pattern
    function is_ctl_skip;
        input [9:0] a;
        input [9:0] b;
        begin
            is_ctl_skip = ((a == `RMLS_CTRL1) && (b == `RMLS_SKIP1)) ||
                          ((a == `RMLS_CTRL2) && (b == `RMLS_SKIP2));
        end
    endfunction

    function is_ctl_or_skip;
        input [9:0] c;
        begin
            is_ctl_or_skip = (c == `RMLS_CTRL1) || (c == `RMLS_SKIP1) ||
                             (c == `RMLS_CTRL2) || (c == `RMLS_SKIP2);
        end
    endfunction

    // ------------------------------------------------------------------
    // Link sampling: two flops before any logic, then edge detect
    // ------------------------------------------------------------------
    reg [2:0] lclk_q;
    reg [9:0] code_s1_q;
    reg [9:0] code_s2_q;
    reg       err_s1_q;
    reg       err_s2_q;

    wire rst     = sys_rst_i | rx_logic_rst_i;
    wire sym_stb = lclk_q[1] & ~lclk_q[2];

    // Link clock is only sampled; the write side moves on its rising edges
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            lclk_q    <= 3'h0;
            code_s1_q <= 10'h000;
            code_s2_q <= 10'h000;
            err_s1_q  <= 1'b0;
            err_s2_q  <= 1'b0;
        end else begin
            lclk_q    <= {lclk_q[1:0], rx_clk_i};
            code_s1_q <= rx_code_i;
            code_s2_q <= code_s1_q;
            err_s1_q  <= rx_code_err_i;
            err_s2_q  <= err_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Lane sync and matcher enable
    // ------------------------------------------------------------------
    wire lane_sync;

    rmls_lane_sync u_sync (
        .clk_i     (clk_i),
        .rst_i     (rst),
        .sym_stb_i (sym_stb),
        .sym_i     (code_s2_q),
        .sym_err_i (err_s2_q),
        .sync_o    (lane_sync)
    );

    assign sync_o = lane_sync;

    // Matcher idles until sync; packet mode also needs its enable
    wire rm_act = lane_sync & (~mode_srio_i | srio_rm_en_i);

    // ------------------------------------------------------------------
    // FIFO
    // ------------------------------------------------------------------
    wire          wr_en;
    wire          rd_en;
    wire [9:0]    rd_data;
    wire          fifo_full;
    wire          fifo_empty;
    wire [AW:0]   level;
    reg  [9:0]    hold_q;
    reg           hold_vld_q;
    reg           del_clu_q;

    rmls_fifo #(
        .W  (10),
        .AW (AW)
    ) u_fifo (
        .clk_i     (clk_i),
        .rst_i     (rst),
        .wr_en_i   (wr_en),
        .wr_data_i (hold_q),
        .rd_en_i   (rd_en),
        .rd_data_o (rd_data),
        .full_o    (fifo_full),
        .empty_o   (fifo_empty),
        .level_o   (level)
    );

    // Thresholds leave room for 200 ppm drift over the longest frame
    wire lvl_high = (level >= HI_LEVEL);
    wire lvl_low  = (level <  LO_LEVEL);

    // ------------------------------------------------------------------
    // Write side: one symbol held back so a pair can be dropped whole
    // ------------------------------------------------------------------
    // Gigabit: drop both symbols of an idle set, or a config head
    wire gige_del = rm_act & ~mode_srio_i & lvl_high & hold_vld_q & is_comma(hold_q) &
                    (is_idle2(code_s2_q) | (autoneg_en_i & is_cfg2(code_s2_q)));
    // Packet mode: drop only the skip, once per cluster
    wire srio_del = rm_act & mode_srio_i & lvl_high & hold_vld_q & ~del_clu_q &
                    is_ctl_skip(hold_q, code_s2_q);
    wire del_evt  = sym_stb & (gige_del | srio_del);

    assign wr_en = sym_stb & hold_vld_q & ~gige_del & ~srio_del;

    always @(posedge clk_i) begin
        if (rst) begin
            hold_q     <= 10'h000;
            hold_vld_q <= 1'b0;
            del_clu_q  <= 1'b0;
        end else if (sym_stb) begin
            if (gige_del) begin
                hold_vld_q <= 1'b0;
            end else if (srio_del) begin
                del_clu_q  <= 1'b1;
            end else begin
                hold_q     <= code_s2_q;
                hold_vld_q <= 1'b1;
                if (!is_ctl_or_skip(code_s2_q)) begin
                    del_clu_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read side: local symbol rate, with replay for insertion
    // ------------------------------------------------------------------
    reg [7:0] rd_cnt_q;
    reg [9:0] out_q;
    reg [9:0] prev_q;
    reg       out_vld_q;
    reg       stb_q;
    reg [9:0] ins_b_q;
    reg       ins_left_q;
    reg       ins_clu_q;

    wire rd_tick  = (rd_cnt_q == RD_LAST);
    wire gige_ins = rm_act & ~mode_srio_i & lvl_low & out_vld_q & is_comma(prev_q) &
                    (is_idle2(out_q) | (autoneg_en_i & is_cfg2(out_q)));
    wire srio_ins = rm_act & mode_srio_i & lvl_low & out_vld_q & ~ins_clu_q &
                    is_ctl_skip(prev_q, out_q);
    wire ins_go   = rd_tick & ~ins_left_q & (gige_ins | srio_ins);
    wire ins_evt  = ins_go;

    // Empty is reported only on a read tick where no automatic insert is due
    assign rd_en = rd_tick & ~ins_left_q & ~gige_ins & ~srio_ins;

    // Local symbol rate divider
    always @(posedge clk_i) begin
        if (rst) begin
            rd_cnt_q <= 8'h00;
        end else if (rd_tick) begin
            rd_cnt_q <= 8'h00;
        end else begin
            rd_cnt_q <= rd_cnt_q + 8'd1;
        end
    end

    // Output symbol register and insertion replay
    always @(posedge clk_i) begin
        if (rst) begin
            out_q      <= 10'h000;
            prev_q     <= 10'h000;
            out_vld_q  <= 1'b0;
            stb_q      <= 1'b0;
            ins_b_q    <= 10'h000;
            ins_left_q <= 1'b0;
            ins_clu_q  <= 1'b0;
        end else begin
            stb_q <= 1'b0;
            if (rd_tick) begin
                if (ins_left_q) begin
                    // Second symbol of a replayed idle set
                    prev_q     <= out_q;
                    out_q      <= ins_b_q;
                    stb_q      <= 1'b1;
                    ins_left_q <= 1'b0;
                end else if (gige_ins) begin
                    prev_q     <= out_q;
                    out_q      <= prev_q;
                    ins_b_q    <= out_q;
                    stb_q      <= 1'b1;
                    ins_left_q <= 1'b1;
                end else if (srio_ins) begin
                    prev_q    <= out_q;
                    stb_q     <= 1'b1;
                    ins_clu_q <= 1'b1;
                end else if (!fifo_empty) begin
                    prev_q    <= out_q;
                    out_q     <= rd_data;
                    out_vld_q <= 1'b1;
                    stb_q     <= 1'b1;
                    if (!is_ctl_or_skip(rd_data)) begin
                        ins_clu_q <= 1'b0;
                    end
                end else begin
                    out_vld_q <= 1'b0;
                end
            end
        end
    end

    assign rx_sym_o     = out_q;
    assign rx_sym_vld_o = stb_q;

    // ------------------------------------------------------------------
    // Event pulses and stretched full/empty flags
    // ------------------------------------------------------------------
    reg [1:0] del_cnt_q;
    reg [1:0] ins_cnt_q;
    reg [4:0] full_cnt_q;
    reg [4:0] empty_cnt_q;

    // Fabric sees every set: pulses last two clocks, sets are 2 symbols apart
    always @(posedge clk_i) begin
        if (rst) begin
            del_cnt_q <= 2'h0;
            ins_cnt_q <= 2'h0;
        end else begin
            if (del_evt) begin
                del_cnt_q <= `RMLS_PULSE_CYC;
            end else if (del_cnt_q != 2'h0) begin
                del_cnt_q <= del_cnt_q - 2'd1;
            end
            if (ins_evt) begin
                ins_cnt_q <= `RMLS_PULSE_CYC;
            end else if (ins_cnt_q != 2'h0) begin
                ins_cnt_q <= ins_cnt_q - 2'd1;
            end
        end
    end

    // Flags span at least two link periods, then clear without a reset
    always @(posedge clk_i) begin
        if (rst) begin
            full_cnt_q  <= 5'h00;
            empty_cnt_q <= 5'h00;
        end else begin
            if (sym_stb && hold_vld_q && fifo_full) begin
                full_cnt_q <= FLAG_CYC;
            end else if (full_cnt_q != 5'h00) begin
                full_cnt_q <= full_cnt_q - 5'd1;
            end
            if (rd_en && fifo_empty) begin
                empty_cnt_q <= FLAG_CYC;
            end else if (empty_cnt_q != 5'h00) begin
                empty_cnt_q <= empty_cnt_q - 5'd1;
            end
        end
    end

    assign rm_del_o   = (del_cnt_q != 2'h0);
    assign rm_ins_o   = (ins_cnt_q != 2'h0);
    assign rm_full_o  = (full_cnt_q != 5'h00);
    assign rm_empty_o = (empty_cnt_q != 5'h00);

    // Single lane only; grouping four lanes needs deskew outside.

endmodule

`default_nettype wire

/* testbench/rmls_far_end.sv */
/* Far-end model: remote transmitter making the link clock and code groups.
   Assumes the bench calls send_sym; the link clock rests low between frames. */
`timescale 1ns/100ps
`default_nettype none
module rmls_far_end (
    output logic       rx_clk_o,
    output logic [9:0] rx_code_o,
    output logic       rx_err_o
);
    // Idle line before the first frame
    initial begin
        rx_clk_o = 1'b0;
        rx_code_o = 10'h155;
        rx_err_o = 1'b0;
    end
    // One group per 48 ns; lines inverted once the hold window ends
    task automatic send_sym(input logic [9:0] sym, input logic err);
        rx_code_o = sym;
        rx_err_o = err;
        #12 rx_clk_o = 1'b1;
        #24 rx_clk_o = 1'b0;
        rx_code_o = ~sym;
        rx_err_o = ~err;
        #12;
    endtask
endmodule
`default_nettype wire

/* testbench/rmls_rate_match_props.sv */
/* Checker of the rate matcher ports: pulse and flag lengths, sync, add/drop.
   Assumes it is bound to rmls_rate_match and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
`include "rmls_consts.vh"
module rmls_rate_match_chk (
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic       rx_clk_i,
    input wire logic [9:0] rx_code_i,
    input wire logic       rx_code_err_i,
    input wire logic       mode_srio_i,
    input wire logic       srio_rm_en_i,
    input wire logic       autoneg_en_i,
    input wire logic       rx_logic_rst_i,
    input wire logic [9:0] rx_sym_o,
    input wire logic       rx_sym_vld_o,
    input wire logic       sync_o,
    input wire logic       rm_del_o,
    input wire logic       rm_ins_o,
    input wire logic       rm_full_o,
    input wire logic       rm_empty_o
);
    // ----
    // Helper counters
    // ----
    logic       rxc_q;
    logic       off_q;
    logic [7:0] lk_q;
    logic [4:0] fl_q;
    logic [4:0] em_q;
    wire        any_rst = sys_rst_i | rx_logic_rst_i;
    // Link rises since reset, high run of each flag; counters saturate
    always @(posedge clk_i) begin
        rxc_q <= rx_clk_i;
        off_q <= mode_srio_i & ~srio_rm_en_i;
        if (any_rst) begin
            lk_q <= 8'h00;
            fl_q <= 5'h00;
            em_q <= 5'h00;
        end else begin
            lk_q <= lk_q + {7'h00, rx_clk_i & ~rxc_q & (lk_q != 8'hff)};
            fl_q <= rm_full_o ? fl_q + {4'h0, fl_q != 5'h1f} : 5'h00;
            em_q <= rm_empty_o ? em_q + {4'h0, em_q != 5'h1f} : 5'h00;
        end
    end
    // ----
    // Assertions
    // ----
    default clocking @(posedge clk_i); endclocking
    default disable iff (any_rst);
    a_del_two_cyc: assert property ($rose(rm_del_o) |=> rm_del_o ##1 !rm_del_o)
        else $error("delete pulse length wrong");
    a_ins_two_cyc: assert property ($rose(rm_ins_o) |=> rm_ins_o ##1 !rm_ins_o)
        else $error("insert pulse length wrong");
    a_full_min_len: assert property ($fell(rm_full_o) |-> fl_q >= 5'd24)
        else $error("full flag too short");
    a_empty_min_len: assert property ($fell(rm_empty_o) |-> em_q >= 5'd24)
        else $error("empty flag too short");
    a_sync_after_commas: assert property ($rose(sync_o) |-> lk_q >= 8'd127)
        else $error("sync before enough commas");
    a_fix_needs_sync: assert property ($rose(rm_del_o | rm_ins_o) |-> $past(sync_o))
        else $error("add or drop without sync");
    a_rm_off_quiet: assert property (off_q |-> !$rose(rm_del_o | rm_ins_o))
        else $error("matcher acted while disabled");
    a_ins_whole_set: assert property ($rose(rm_ins_o) && !mode_srio_i |->
        (rx_sym_o inside {`RMLS_K285_N, `RMLS_K285_P}) ##1 (!rx_sym_vld_o)[*8] ##[1:8]
        (rx_sym_vld_o && rx_sym_o inside {`RMLS_D162_N, `RMLS_D162_P, `RMLS_D22_N, `RMLS_D22_P}))
        else $error("inserted set not whole");
endmodule
bind rmls_rate_match rmls_rate_match_chk u_chk (
    .clk_i, .sys_rst_i, .rx_clk_i, .rx_code_i, .rx_code_err_i, .mode_srio_i, .srio_rm_en_i, .autoneg_en_i,
    .rx_logic_rst_i, .rx_sym_o, .rx_sym_vld_o, .sync_o, .rm_del_o, .rm_ins_o, .rm_full_o, .rm_empty_o
);
`default_nettype wire

/* testbench/rmls_rate_match_tb.sv */
/* Testbench of the rate matcher: far-end model, fabric controls, watcher.
   Assumes 4 ns local clock, 48 ns link; read side slowed so the FIFO fills. */
`timescale 1ns/100ps
`default_nettype none
`include "rmls_consts.vh"
module rmls_rate_match_tb;
    logic       clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       mode_srio_i = 1'b0;
    logic       srio_rm_en_i = 1'b0;
    logic       autoneg_en_i = 1'b0;
    logic       rx_logic_rst_i = 1'b0;
    logic       rx_clk, rx_err, vld, sync, del, ins, full, empty;
    logic [9:0] rx_code, rx_sym;
    logic [9:0] exp_q[$];
    int         miscompares = 0;
    int         total_checks = 0;
    int         n_del = 0;
    int         n_ins = 0;
    int         i, k;
    // 250 MHz local clock
    always #2 clk_i = ~clk_i;
    rmls_far_end u_far (.rx_clk_o(rx_clk), .rx_code_o(rx_code), .rx_err_o(rx_err));
    rmls_rate_match #(.RD_DIV(13)) u_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .rx_clk_i(rx_clk), .rx_code_i(rx_code), .rx_code_err_i(rx_err),
        .mode_srio_i(mode_srio_i), .srio_rm_en_i(srio_rm_en_i), .autoneg_en_i(autoneg_en_i),
        .rx_logic_rst_i(rx_logic_rst_i), .rx_sym_o(rx_sym), .rx_sym_vld_o(vld), .sync_o(sync),
        .rm_del_o(del), .rm_ins_o(ins), .rm_full_o(full), .rm_empty_o(empty));
    // ----
    // Checking and ending
    // ----
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: flag %b", $time, got);
        end
    endtask
    task automatic chk_sym(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: symbol %h not %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            miscompares++;
            $display("unexpected at %0t: wait ran out", $time);
            end_sim;
        end
    endtask
    // ----
    // Stimulus helpers
    // ----
    function automatic logic spec(input logic [9:0] s);
        return s inside {`RMLS_K285_N, `RMLS_K285_P, `RMLS_D162_N, `RMLS_D162_P,
                         `RMLS_D22_N, `RMLS_D22_P, `RMLS_K297_N, `RMLS_K297_P};
    endfunction
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Random data avoids idle and control codes so it is never a candidate
    task automatic send_data(input int n);
        logic [9:0] d;
        repeat (n) begin
            do d = 10'($urandom); while (spec(d));
            exp_q.push_back(d);
            u_far.send_sym(d, 1'b0);
        end
    endtask
    task automatic send_idle(input int n, input logic [9:0] second);
        repeat (n) begin
            u_far.send_sym(`RMLS_K285_N, 1'b0);
            u_far.send_sym(second, 1'b0);
        end
    endtask
    task automatic fab_rst;
        @(posedge clk_i) rx_logic_rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rx_logic_rst_i <= 1'b0;
        settle(2);
    endtask
    task automatic sync_up;
        repeat (126) u_far.send_sym(`RMLS_K285_N, 1'b0);
        settle(30);
        chk_bit(sync, 1'b0);
        u_far.send_sym(`RMLS_K285_N, 1'b0);
        for (i = 0; i < 40 && sync !== 1'b1; i++) @(posedge clk_i);
        bound(i, 40);
        chk_bit(sync, 1'b1);
    endtask
    // Watcher: data groups leave in order, never added or dropped
    always @(posedge clk_i) begin
        if (vld === 1'b1 && !spec(rx_sym))
            chk_sym(rx_sym, exp_q.size() > 0 ? exp_q.pop_front() : ~rx_sym);
        if ($rose(del)) n_del++;
        if ($rose(ins)) n_ins++;
    end
    // ----
    // Main sequence
    // ----
    initial begin
        void'($urandom(99));
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        settle(2);
        chk_bit(sync | del | ins | full | empty | vld, 1'b0);
        sync_up;
        // Two errors, a long good run, then one more error each time
        repeat (2) u_far.send_sym(`RMLS_D162_N, 1'b1);
        k = n_del;
        send_idle(128, `RMLS_D162_N);
        chk_bit(n_del > k, 1'b1);
        u_far.send_sym(`RMLS_D162_N, 1'b1);
        settle(30);
        chk_bit(sync, 1'b1);
        u_far.send_sym(`RMLS_D162_N, 1'b1);
        settle(30);
        chk_bit(sync, 1'b0);
        // Link silent without sync: drains to empty, nothing added
        for (i = 0; i < 400 && empty !== 1'b1; i++) @(posedge clk_i);
        bound(i, 400);
        chk_bit(empty, 1'b1);
        fab_rst;
        chk_bit(sync | empty, 1'b0);
        sync_up;
        k = n_del;
        repeat (16) begin
            send_data(3);
            send_idle(2, `RMLS_D162_N);
        end
        chk_bit(n_del > k, 1'b1);
        @(posedge clk_i) autoneg_en_i <= 1'b1;
        k = n_del;
        repeat (16) begin
            send_data(3);
            send_idle(1, `RMLS_D22_N);
        end
        chk_bit(n_del > k, 1'b1);
        // Stop after an idle set so the drained FIFO must insert
        send_idle(2, `RMLS_D162_N);
        u_far.send_sym(`RMLS_K285_N, 1'b0);
        k = n_ins;
        for (i = 0; i < 800 && n_ins == k; i++) @(posedge clk_i);
        bound(i, 800);
        chk_bit(n_ins > k, 1'b1);
        @(posedge clk_i) begin
            mode_srio_i <= 1'b1;
            srio_rm_en_i <= 1'b1;
        end
        k = n_del;
        for (i = 0; i < 40; i++) begin
            u_far.send_sym(i[0] ? `RMLS_K285_N : `RMLS_K285_P, 1'b0);
            repeat (2) u_far.send_sym(i[0] ? `RMLS_K297_N : `RMLS_K297_P, 1'b0);
            send_data(2);
        end
        chk_bit(n_del > k && n_del <= k + 40, 1'b1);
        // Matcher off: skips pass untouched until the FIFO overflows
        @(posedge clk_i) srio_rm_en_i <= 1'b0;
        for (i = 0; i < 60 && full !== 1'b1; i++) begin
            u_far.send_sym(`RMLS_K285_P, 1'b0);
            u_far.send_sym(`RMLS_K297_P, 1'b0);
        end
        bound(i, 60);
        chk_bit(full, 1'b1);
        // Link quiet: the flag must run out on its own
        settle(30);
        chk_bit(full, 1'b0);
        fab_rst;
        chk_bit(sync | full, 1'b0);
        end_sim;
    end
endmodule
`default_nettype wire
